// ==== rtl/parallel_port.sv ====
// Notes on behaviour
// - Chip-select function 10 makes pin a chip select; 01/00 address bit 14; 11 reserved.
// - Address latch polarity bit 5 sets latch strobes active-high or active-low.
// - Chip-select polarity bit 3 sets chip-select active-high or active-low.
// - In modes 00,01,10 write polarity bit 1 sets write strobe polarity.
// - In mode 11 write polarity bit sets enable strobe polarity.
// - In modes 00,01,10 read polarity bit 0 sets read strobe polarity.
// - In mode 11 read polarity bit sets read/write direction strobe polarity.
// - Polarity and function settings do not affect pins used as address lines.
// - Input all-full bit 15 set only when all four input buffers hold data.
// - Input overflow bit 14 set on host write to full buffer; software clears.
// - Per-buffer input full bits 11-8 set on data, cleared by software read.
// - Output all-empty bit 7 resets to one, set only when all buffers empty.
// - Output underflow bit 6 set on host read of empty buffer; software clears.
// - Per-buffer output empty bits 3-0 reset one, cleared by write until sent.
// - Status meaningful in slave modes; bits 31-16, 13-12, 5-4 read zero.
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module parallel_port
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pport_pkg::wb_req_t wb_req_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   output logic irq_o,
   input wire pport_pkg::pins_t pins_i,
   output logic [7:0] port_data_o,
   output logic port_data_oe_o,
   output logic chip_select_pin_o,
   output logic chip_select_pin_oe_o,
   output logic read_strobe_pin_o,
   output logic read_strobe_pin_oe_o,
   output logic write_strobe_pin_o,
   output logic write_strobe_pin_oe_o,
   output logic address_latch_low_strobe_o,
   output logic address_latch_high_strobe_o
);
   import pport_pkg::*;

   state_t q;
   state_t n;

   function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                           input logic [1:0] sel);
      logic [15:0] r;
      r = old_v;
      if (sel[0])
      begin
         r[7:0] = new_v[7:0];
      end
      if (sel[1])
      begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction

   logic enabled;
   logic slave_mode;
   logic master_mode;
   logic [1:0] mode;
   logic [1:0] chip_select_function;
   logic cs_act;
   logic rd_act;
   logic wr_act;
   logic [31:0] status_word;

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration decode
   assign enabled = q.ctrl[CTL_ENABLE];
   assign mode = q.ctrl[CTL_MODE_HI:CTL_MODE_LO];
   assign chip_select_function = q.ctrl[CTL_CSF_HI:CTL_CSF_LO];
   assign slave_mode = enabled & ~mode[1];
   assign master_mode = enabled & mode[1];

   // Slave side: pin in chip-select role is qualified by its polarity
   assign cs_act = (chip_select_function == CSF_CHIP_SELECT) ? (q.s2.cs == q.ctrl[CTL_CS_POL]) : 1'b1;
   assign rd_act = slave_mode & cs_act & (q.s2.rd == q.ctrl[CTL_RD_POL]);
   assign wr_act = slave_mode & cs_act & (q.s2.wr == q.ctrl[CTL_WR_POL]);

   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[ST_IN_ALL_FULL] = &q.in_full;
      status_word[ST_IN_OVERFLOW] = q.in_ovf;
      status_word[ST_IN_FULL_LO +: NUM_BUF] = q.in_full;
      status_word[ST_OUT_ALL_EMPTY] = &q.out_empty;
      status_word[ST_OUT_UNDERFLOW] = q.out_unf;
      status_word[ST_OUT_EMPTY_LO +: NUM_BUF] = q.out_empty;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      logic take;
      logic [1:0] bidx;
      logic [3:0] ev;
      logic [7:0] adr;
      n = q;
      take = wb_req_i.cyc & wb_req_i.stb & ~q.ack;
      adr = wb_req_i.adr;
      bidx = adr[3:2];
      ev = 4'h0;
      n.s1 = pins_i;
      n.s2 = q.s1;
      n.rd_prev = rd_act;
      n.wr_prev = wr_act;
      n.ack = take;

      // Software side
      if (take)
      begin
         n.rdat = 32'h0000_0000;
         if (wb_req_i.we)
         begin
            unique case (adr)
               OFS_CONTROL:
               begin
                  n.ctrl = merge16(q.ctrl, wb_req_i.dat[15:0], wb_req_i.sel[1:0])
                           & CTL_WRITE_MASK;
               end
               OFS_STATUS:
               begin
                  // Only a zero written to a sticky flag clears it
                  if (wb_req_i.sel[1] && !wb_req_i.dat[ST_IN_OVERFLOW])
                  begin
                     n.in_ovf = 1'b0;
                  end
                  if (wb_req_i.sel[0] && !wb_req_i.dat[ST_OUT_UNDERFLOW])
                  begin
                     n.out_unf = 1'b0;
                  end
               end
               OFS_IRQ_MASK:
               begin
                  if (wb_req_i.sel[0])
                  begin
                     n.irq_mask = wb_req_i.dat[3:0];
                  end
               end
               OFS_MASTER_DRIVE:
               begin
                  if (wb_req_i.sel[0])
                  begin
                     n.master = wb_req_i.dat[7:0];
                  end
               end
               default:
               begin
                  if ((adr & BUF_GROUP_MASK) == OFS_OUT_BUF0 && wb_req_i.sel[0])
                  begin
                     n.out_buf[bidx] = wb_req_i.dat[7:0];
                     n.out_empty[bidx] = 1'b0;
                  end
               end
            endcase
         end
         else
         begin
            unique case (adr)
               OFS_CONTROL: n.rdat = {16'h0000, q.ctrl};
               OFS_STATUS: n.rdat = status_word;
               OFS_IRQ_STATUS:
               begin
                  n.rdat = {28'h000_0000, q.irq_stat};
                  n.irq_stat = 4'h0;
               end
               OFS_IRQ_MASK: n.rdat = {28'h000_0000, q.irq_mask};
               OFS_MASTER_DRIVE: n.rdat = {24'h00_0000, q.master};
               default:
               begin
                  if ((adr & BUF_GROUP_MASK) == OFS_IN_BUF0)
                  begin
                     n.rdat = {24'h00_0000, q.in_buf[bidx]};
                     n.in_full[bidx] = 1'b0;
                  end
                  else if ((adr & BUF_GROUP_MASK) == OFS_OUT_BUF0)
                  begin
                     n.rdat = {24'h00_0000, q.out_buf[bidx]};
                  end
               end
            endcase
         end
      end

      // Host side, applied after software so a set wins over a clear
      if (wr_act && !q.wr_prev)
      begin
         if (n.in_full[q.s2.addr])
         begin
            n.in_ovf = 1'b1;
            ev[EV_OVERFLOW] = 1'b1;
         end
         else
         begin
            n.in_buf[q.s2.addr] = q.s2.data;
            n.in_full[q.s2.addr] = 1'b1;
            ev[EV_HOST_WROTE] = 1'b1;
         end
      end
      if (rd_act && !q.rd_prev)
      begin
         n.pdata = n.out_buf[q.s2.addr];
         if (n.out_empty[q.s2.addr])
         begin
            n.out_unf = 1'b1;
            ev[EV_UNDERFLOW] = 1'b1;
         end
         else
         begin
            n.out_empty[q.s2.addr] = 1'b1;
            ev[EV_HOST_READ] = 1'b1;
         end
      end
      n.irq_stat = n.irq_stat | ev;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.ctrl <= CTL_RESET;
         q.out_empty <= '1;
      end
      else
      begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;
   assign irq_o = |(q.irq_stat & q.irq_mask);

   // Data is driven only once the latched byte is valid
   assign port_data_o = q.pdata;
   assign port_data_oe_o = rd_act & q.rd_prev;

   always_comb
   begin
      chip_select_pin_oe_o = master_mode;
      if (chip_select_function == CSF_CHIP_SELECT)
      begin
         chip_select_pin_o = ~(q.master[MD_CS] ^ q.ctrl[CTL_CS_POL]);
      end
      else
      begin
         chip_select_pin_o = q.master[MD_ADDR14];
      end
   end

   // Mode 10 drives read and write strobes; mode 11 drives direction and enable
   assign read_strobe_pin_oe_o = master_mode;
   assign read_strobe_pin_o = ~(q.master[MD_RD] ^ q.ctrl[CTL_RD_POL]);
   assign write_strobe_pin_oe_o = master_mode;
   assign write_strobe_pin_o = ~(q.master[MD_WR] ^ q.ctrl[CTL_WR_POL]);

   always_comb
   begin
      if (q.ctrl[CTL_LATCH_EN])
      begin
         address_latch_low_strobe_o = ~(q.master[MD_LATCH_LO] ^ q.ctrl[CTL_ALP]);
         address_latch_high_strobe_o = ~(q.master[MD_LATCH_HI] ^ q.ctrl[CTL_ALP]);
      end
      else
      begin
         address_latch_low_strobe_o = q.master[MD_ADDR_LO_PIN];
         address_latch_high_strobe_o = q.master[MD_ADDR_HI_PIN];
      end
   end
endmodule

// ==== rtl/pport_pkg.sv ====
package pport_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_MASTER_DRIVE = 8'h10;
   localparam logic [7:0] OFS_IN_BUF0 = 8'h20;
   localparam logic [7:0] OFS_OUT_BUF0 = 8'h30;
   localparam logic [7:0] BUF_GROUP_MASK = 8'hF0;

   // Control fields
   localparam int CTL_ENABLE = 15;
   localparam int CTL_LATCH_EN = 11;
   localparam int CTL_MODE_HI = 9;
   localparam int CTL_MODE_LO = 8;
   localparam int CTL_CSF_HI = 7;
   localparam int CTL_CSF_LO = 6;
   localparam int CTL_ALP = 5;
   localparam int CTL_CS_POL = 3;
   localparam int CTL_WR_POL = 1;
   localparam int CTL_RD_POL = 0;
   localparam logic [15:0] CTL_WRITE_MASK = 16'h8BEB;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [1:0] CSF_CHIP_SELECT = 2'b10;
   localparam logic [1:0] MODE_MASTER_2 = 2'b10;
   localparam logic [1:0] MODE_MASTER_1 = 2'b11;

   // Status fields
   localparam int ST_IN_ALL_FULL = 15;
   localparam int ST_IN_OVERFLOW = 14;
   localparam int ST_IN_FULL_LO = 8;
   localparam int ST_OUT_ALL_EMPTY = 7;
   localparam int ST_OUT_UNDERFLOW = 6;
   localparam int ST_OUT_EMPTY_LO = 0;

   // Interrupt events
   localparam int EV_HOST_WROTE = 0;
   localparam int EV_HOST_READ = 1;
   localparam int EV_OVERFLOW = 2;
   localparam int EV_UNDERFLOW = 3;

   // Master drive fields
   localparam int MD_CS = 0;
   localparam int MD_LATCH_LO = 1;
   localparam int MD_LATCH_HI = 2;
   localparam int MD_RD = 3;
   localparam int MD_WR = 4;
   localparam int MD_ADDR14 = 5;
   localparam int MD_ADDR_LO_PIN = 6;
   localparam int MD_ADDR_HI_PIN = 7;

   localparam int NUM_BUF = 4;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic cs;
      logic rd;
      logic wr;
      logic [1:0] addr;
      logic [7:0] data;
   } pins_t;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [7:0] master;
      logic [3:0][7:0] in_buf;
      logic [3:0] in_full;
      logic in_ovf;
      logic [3:0][7:0] out_buf;
      logic [3:0] out_empty;
      logic out_unf;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      pins_t s1;
      pins_t s2;
      logic rd_prev;
      logic wr_prev;
      logic [7:0] pdata;
      logic ack;
      logic [31:0] rdat;
   } state_t;
endpackage

// ==== tb/parallel_port_assertions.sv ====
`timescale 1ns/1ps
module parallel_port_assertions
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pport_pkg::wb_req_t wb_req_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic irq_o,
   input wire logic port_data_oe_o,
   input wire logic read_strobe_pin_oe_o
);
   import pport_pkg::*;
   logic st_rd;
   assign st_rd = wb_ack_o && !wb_req_i.we && wb_req_i.adr == OFS_STATUS;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_answers: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_dat_held: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("dat moved");
   a_status_unused: assert property (st_rd |-> (wb_dat_o & 32'hFFFF_3030) == 32'h0000_0000)
      else $error("unused status bits set");
   a_full_and: assert property (st_rd |-> wb_dat_o[15] == &wb_dat_o[11:8])
      else $error("all-full wrong");
   a_empty_and: assert property (st_rd |-> wb_dat_o[7] == &wb_dat_o[3:0])
      else $error("all-empty wrong");
   a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !port_data_oe_o)
      else $error("outputs active after reset");
   a_mode_exclusive: assert property (port_data_oe_o |-> !read_strobe_pin_oe_o)
      else $error("slave and master drive together");
endmodule

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
module host_model
(
   input wire logic clk_i,
   input wire logic wr_hi_i,
   input wire logic rd_hi_i,
   input wire logic [7:0] port_data_i,
   input wire logic port_data_oe_i,
   output pport_pkg::pins_t pins_o
);
   import pport_pkg::*;
   logic rd_on = 1'b0;
   logic wr_on = 1'b0;
   logic [1:0] a_q = 2'h0;
   logic [7:0] d_q = 8'h00;
   // Inactive strobe level follows the configured polarity
   assign pins_o = '{1'b1, rd_on ~^ rd_hi_i, wr_on ~^ wr_hi_i, a_q, d_q};
   task write_byte(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      a_q <= a;
      d_q <= d;
      repeat (3) @(posedge clk_i);
      wr_on <= 1'b1;
      repeat (5) @(posedge clk_i);
      wr_on <= 1'b0;
      repeat (3) @(posedge clk_i);
      d_q <= ~d;
   endtask
   task read_byte(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_i);
      a_q <= a;
      repeat (3) @(posedge clk_i);
      rd_on <= 1'b1;
      repeat (5) @(posedge clk_i);
      d = port_data_oe_i ? port_data_i : 8'hxx;
      rd_on <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
endmodule

// ==== tb/parallel_port_test.sv ====
`timescale 1ns/1ps
module parallel_port_test;
   import pport_pkg::*;
   logic clk_i, rst_i, irq_o, ack, wr_hi, rd_hi, oe;
   logic [31:0] dat, rdat;
   logic [7:0] pd, hb;
   logic cs_o, cs_oe, rs_o, rs_oe, ws_o, ws_oe, al_lo, al_hi;
   wb_req_t req;
   pins_t pins;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   parallel_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(ack),
      .wb_dat_o(dat), .irq_o(irq_o), .pins_i(pins), .port_data_o(pd), .port_data_oe_o(oe),
      .chip_select_pin_o(cs_o), .chip_select_pin_oe_o(cs_oe), .read_strobe_pin_o(rs_o),
      .read_strobe_pin_oe_o(rs_oe), .write_strobe_pin_o(ws_o), .write_strobe_pin_oe_o(ws_oe),
      .address_latch_low_strobe_o(al_lo), .address_latch_high_strobe_o(al_hi));
   host_model u_host (.clk_i(clk_i), .wr_hi_i(wr_hi), .rd_hi_i(rd_hi), .port_data_i(pd),
      .port_data_oe_i(oe), .pins_o(pins));
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         miscompares++;
         final_report;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task final_report;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req <= '{1'b1, 1'b1, we, a, 4'hF, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat;
      req <= '0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask
   task chk_pins(input logic [7:0] e);
      chk({24'h00_0000, cs_oe, cs_o, rs_oe, rs_o, ws_oe, ws_o, al_hi, al_lo}, {24'h00_0000, e});
   endtask
   task host_rd(input logic [1:0] a, input logic [7:0] e);
      u_host.read_byte(a, hb);
      chk({24'h00_0000, hb}, {24'h00_0000, e});
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(OFS_STATUS, 32'h0000_008F);
      rd(8'h44, 32'h0000_0000);
      wb(1'b1, OFS_CONTROL, 32'hFFFF_FFFF);
      rd(OFS_CONTROL, 32'h0000_8BEB);
      wb(1'b1, OFS_CONTROL, 32'h0000_8000);
   endtask
   task t_in;
      wb(1'b1, OFS_IRQ_MASK, 32'h0000_000F);
      for (int i = 0; i < 3; i++)
         u_host.write_byte(i[1:0], 8'hA0 + i[7:0]);
      rd(OFS_STATUS, 32'h0000_078F);
      u_host.write_byte(2'h3, 8'hA3);
      rd(OFS_STATUS, 32'h0000_8F8F);
      chk({31'h0000_0000, irq_o}, 32'h0000_0001);
      u_host.write_byte(2'h0, 8'h55);
      rd(OFS_STATUS, 32'h0000_CF8F);
      rd(OFS_IRQ_STATUS, 32'h0000_0005);
      chk({31'h0000_0000, irq_o}, 32'h0000_0000);
      rd(OFS_IN_BUF0, 32'h0000_00A0);
      rd(OFS_STATUS, 32'h0000_4E8F);
      wb(1'b1, OFS_STATUS, 32'h0000_0000);
      for (int i = 1; i < 4; i++)
         rd(OFS_IN_BUF0 + 8'(4 * i), 32'h0000_00A0 + i);
      rd(OFS_STATUS, 32'h0000_008F);
   endtask
   task t_out;
      wb(1'b1, OFS_OUT_BUF0 + 8'h04, 32'h0000_005A);
      rd(OFS_STATUS, 32'h0000_000D);
      host_rd(2'h1, 8'h5A);
      rd(OFS_STATUS, 32'h0000_008F);
      host_rd(2'h2, 8'h00);
      rd(OFS_STATUS, 32'h0000_00CF);
      rd(OFS_IRQ_STATUS, 32'h0000_000A);
      wb(1'b1, OFS_STATUS, 32'h0000_0000);
      rd(OFS_STATUS, 32'h0000_008F);
   endtask
   task t_pol;
      wb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
      wb(1'b1, OFS_CONTROL, 32'h0000_0003);
      wr_hi <= 1'b1;
      rd_hi <= 1'b1;
      wb(1'b1, OFS_CONTROL, 32'h0000_8003);
      u_host.write_byte(2'h3, 8'h3C);
      rd(OFS_STATUS, 32'h0000_088F);
      chk({31'h0000_0000, irq_o}, 32'h0000_0000);
      wb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
      chk({31'h0000_0000, irq_o}, 32'h0000_0001);
      rd(OFS_IN_BUF0 + 8'h0C, 32'h0000_003C);
      wb(1'b1, OFS_OUT_BUF0, 32'h0000_00C3);
      host_rd(2'h0, 8'hC3);
   endtask
   task t_master;
      wb(1'b1, OFS_MASTER_DRIVE, 32'h0000_0005);
      wb(1'b1, OFS_CONTROL, 32'h0000_8AAB);
      chk_pins(8'hEA);
      wb(1'b1, OFS_MASTER_DRIVE, 32'h0000_0018);
      wb(1'b1, OFS_CONTROL, 32'h0000_8B80);
      chk_pins(8'hEB);
      wb(1'b1, OFS_MASTER_DRIVE, 32'h0000_00A0);
      wb(1'b1, OFS_CONTROL, 32'h0000_8268);
      chk_pins(8'hFE);
   endtask
   initial
   begin
      req = '0;
      rst_i = 1'b1;
      wr_hi = 1'b0;
      rd_hi = 1'b0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_in;
      t_out;
      t_pol;
      t_master;
      final_report;
   end
endmodule
bind parallel_port parallel_port_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_o(irq_o),
   .port_data_oe_o(port_data_oe_o), .read_strobe_pin_oe_o(read_strobe_pin_oe_o));
